// ===== hdl/ccrb_pkg.sv
package ccrb_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [10:0] CCRB_BASE_ADDR = 11'h200;
  localparam logic [2:0] CCRB_OFS_OPTION = 3'h0;
  localparam logic [2:0] CCRB_OFS_STATUS = 3'h2;
  localparam logic [2:0] CCRB_OFS_PINREP = 3'h4;
  localparam logic [2:0] CCRB_OFS_SOCKET = 3'h6;
  localparam logic [10:0] CCRB_REG_SPAN_MASK = 11'h7F8;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CCRB_OPT_SOFT_RESET_BIT_BIT = 7;
  localparam int CCRB_OPT_LEVIRQ_BIT = 6;
  localparam int CCRB_STS_CHANGED_BIT = 7;
  localparam int CCRB_STS_CHANGE_SIGNAL_ENABLE_BIT = 6;
  localparam int CCRB_STS_IO8_BIT = 5;
  localparam int CCRB_STS_PL1_BIT = 4;
  localparam int CCRB_STS_AUDIO_BIT = 3;
  localparam int CCRB_STS_PWRDN_BIT = 2;
  localparam int CCRB_STS_INT_BIT = 1;
  localparam int CCRB_PIN_CRDY_BIT = 5;
  localparam int CCRB_PIN_CWP_BIT = 4;
  localparam int CCRB_PIN_RRDY_BIT = 1;
  localparam int CCRB_PIN_WP_BIT = 0;
  localparam int CCRB_SOC_DRV_BIT = 4;

  // ---------------------------------------------------------------
  // Reset values and fixed read bits
  // ---------------------------------------------------------------
  localparam logic [5:0] CCRB_INDEX_RST = 6'h00;
  localparam logic [5:0] CCRB_INDEX_MEM = 6'h00;
  localparam logic [5:0] CCRB_INDEX_IO_ANY = 6'h01;
  localparam logic [5:0] CCRB_INDEX_IO_PRI = 6'h02;
  localparam logic [5:0] CCRB_INDEX_IO_SEC = 6'h03;
  localparam logic [7:0] CCRB_PIN_FIXED_ONES = 8'h0C;
  localparam logic [7:0] CCRB_BYTE_ZERO = 8'h00;

  // Decoded configuration modes
  typedef enum logic [3:0] {
    CCRB_MODE_MEM = 4'b0001,
    CCRB_MODE_IO_ANY = 4'b0010,
    CCRB_MODE_IO_PRI = 4'b0100,
    CCRB_MODE_IO_SEC = 4'b1000
  } ccrb_mode_e;

  // Attribute bus request carried as one bundle
  typedef struct packed {
    logic ce1_b;
    logic reg_b;
    logic oe_b;
    logic we_b;
    logic [10:0] addr;
    logic [7:0] wdata;
  } ccrb_attr_s;

endpackage

// ===== hdl/ccrb_edge_det.sv
`timescale 1ns/1ps
`default_nettype none

// Detects any change of a synchronous level; history reset to zero
module ccrb_edge_det #(
  parameter int WIDTH = 2
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] changed
);

  logic [WIDTH-1:0] hist_reg;

  // ---------------------------------------------------------------
  // Per-bit change detection
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      // Previous value held to compare against live level
      always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
          hist_reg[gi] <= 1'b0;
        end else begin
          hist_reg[gi] <= level[gi];
        end
      end
      assign changed[gi] = hist_reg[gi] ^ level[gi];
    end
  endgenerate

endmodule

`default_nettype wire

// ===== hdl/ccrb_card_config_register_bank.sv
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Writing soft reset one resets the card; the bit stays until written zero.
// - After soft reset returns to zero the card stays unconfigured.
// - Power-up and hardware reset clear the soft reset bit.
// - Bit six selects level interrupts when one, pulse when zero; resets zero.
// - Six-bit index resets zero; 0 memory, 1 any I/O, 2 primary, 3 secondary.
// - Summary flag reflects change flags; drives status pin low when enabled in I/O.
// - Change signal disabled keeps status pin high while configured for I/O.
// - The eight-bit I/O request is ignored; both widths always supported.
// - Power-level-1 disable reads zero and ignores writes.
// - Changing power-down request makes ready busy until state reached.
// - Card powers down when idle and wakes on a command.
// - Interrupt status follows internal request, masked by interrupt disable bit.
// - Change flags set whenever live ready or write-protect state changes.
// - Live ready bit reads the internal ready state.
// - Live write-protect bit always reads zero.
// - Change flags take written value only where mask bit is one.
// - Drive number reads back as written and drives twin card matching.
// - Socket number in the low four bits is ignored.
// - Registers are byte-wide and only at even attribute addresses.
// - Register base sits at 200h with offsets 0, 2, 4 and 6.
module ccrb_card_config_register_bank (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic hw_reset,
  input wire ccrb_pkg::ccrb_attr_s attr_in,
  input wire logic irq_request,
  input wire logic irq_disable_bit,
  input wire logic core_ready,
  input wire logic core_idle,
  input wire logic command_received,
  input wire logic power_state_low,
  output logic [7:0] attr_rdata,
  output logic attr_rdata_oe,
  output logic status_change_pin,
  output logic ready_out,
  output logic card_reset,
  output logic level_irq_select,
  output ccrb_pkg::ccrb_mode_e config_mode,
  output logic io_configured,
  output logic power_down_target,
  output logic drive_select_bit
);
  import ccrb_pkg::*;

  // ---------------------------------------------------------------
  // Stored state
  // ---------------------------------------------------------------
  logic soft_reset_bit_reg;
  logic level_irq_reg;
  logic [5:0] config_index_reg;
  logic change_signal_enable_reg;
  logic eight_bit_io_request_reg;
  logic audio_reg;
  logic power_down_request_reg;
  logic ready_change_flag_reg;
  logic wp_change_flag_reg;
  logic drive_num_reg;
  logic we_b_dly_reg;
  logic busy_reg;
  logic auto_sleep_reg;

  logic any_reset;
  logic sel_regs;
  logic wr_done;
  logic [2:0] ofs;
  logic rd_active;
  logic changed_flag;
  logic int_status;
  logic write_protect_state;
  logic [1:0] live_lvl;
  logic [1:0] live_chg;
  logic [7:0] rd_mux;
  logic pwrdn_wr_change;

  assign write_protect_state = 1'b0; // No switch on the card
  assign any_reset = hw_reset | soft_reset_bit_reg; // Soft reset acts like the pin

  // Base decode, even addresses only; odd bytes never select
  assign sel_regs = !attr_in.ce1_b && !attr_in.reg_b && !attr_in.addr[0] &&
                    ((attr_in.addr & CCRB_REG_SPAN_MASK) == CCRB_BASE_ADDR);
  assign ofs = attr_in.addr[2:0];
  assign rd_active = sel_regs && !attr_in.oe_b && attr_in.we_b;

  // ---------------------------------------------------------------
  // Write strobe edge
  // ---------------------------------------------------------------
  // Commit on the rising edge of the strobe so a long pulse writes once
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      we_b_dly_reg <= 1'b1;
    end else begin
      we_b_dly_reg <= attr_in.we_b;
    end
  end
  assign wr_done = sel_regs && !we_b_dly_reg && attr_in.we_b;

  // ---------------------------------------------------------------
  // Configuration option
  // ---------------------------------------------------------------
  // Soft reset bit cleared by power-up, hardware reset or a host write of zero, never by itself
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      soft_reset_bit_reg <= 1'b0;
    end else if (hw_reset) begin
      soft_reset_bit_reg <= 1'b0;
    end else if (wr_done && ofs == CCRB_OFS_OPTION) begin
      soft_reset_bit_reg <= attr_in.wdata[CCRB_OPT_SOFT_RESET_BIT_BIT];
    end
  end

  // Mode fields cleared during any reset; written only when no reset pends
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      level_irq_reg <= 1'b0;
      config_index_reg <= CCRB_INDEX_RST;
    end else if (any_reset) begin
      level_irq_reg <= 1'b0;
      config_index_reg <= CCRB_INDEX_RST;
    end else if (wr_done && ofs == CCRB_OFS_OPTION && !attr_in.wdata[CCRB_OPT_SOFT_RESET_BIT_BIT]) begin
      level_irq_reg <= attr_in.wdata[CCRB_OPT_LEVIRQ_BIT];
      config_index_reg <= attr_in.wdata[5:0];
    end
  end

  // ---------------------------------------------------------------
  // Configuration and status
  // ---------------------------------------------------------------
  // Host-owned enables; the eight-bit request is stored but steers nothing
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      change_signal_enable_reg <= 1'b0;
      eight_bit_io_request_reg <= 1'b0;
      audio_reg <= 1'b0;
      power_down_request_reg <= 1'b0;
    end else if (any_reset) begin
      change_signal_enable_reg <= 1'b0;
      eight_bit_io_request_reg <= 1'b0;
      audio_reg <= 1'b0;
      power_down_request_reg <= 1'b0;
    end else if (wr_done && ofs == CCRB_OFS_STATUS) begin
      change_signal_enable_reg <= attr_in.wdata[CCRB_STS_CHANGE_SIGNAL_ENABLE_BIT];
      eight_bit_io_request_reg <= attr_in.wdata[CCRB_STS_IO8_BIT]; // Ignored
      audio_reg <= attr_in.wdata[CCRB_STS_AUDIO_BIT];
      power_down_request_reg <= attr_in.wdata[CCRB_STS_PWRDN_BIT];
    end
  end

  assign pwrdn_wr_change = wr_done && ofs == CCRB_OFS_STATUS && !any_reset &&
                           (attr_in.wdata[CCRB_STS_PWRDN_BIT] != power_down_request_reg);

  // Busy from a power request change until the core reports that state
  // Compared with the target's next value: the registered output lags a cycle and would drop busy at once
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      busy_reg <= 1'b0;
    end else if (pwrdn_wr_change) begin
      busy_reg <= 1'b1;
    end else if (busy_reg && power_state_low == (power_down_request_reg | auto_sleep_reg)) begin
      busy_reg <= 1'b0;
    end
  end

  // Idle sleep is automatic and a command wakes the core; command wins
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      auto_sleep_reg <= 1'b0;
    end else if (command_received || any_reset) begin
      auto_sleep_reg <= 1'b0;
    end else if (core_idle) begin
      auto_sleep_reg <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Pin replacement change flags
  // ---------------------------------------------------------------
  assign live_lvl = {core_ready, write_protect_state};

  ccrb_edge_det #(
    .WIDTH(2)
  ) u_edge (
    .mclk(mclk),
    .rst_b(rst_b),
    .level(live_lvl),
    .changed(live_chg)
  );

  // Hardware set beats a host clear in the same cycle
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ready_change_flag_reg <= 1'b0;
      wp_change_flag_reg <= 1'b0;
    end else begin
      if (live_chg[1]) begin
        ready_change_flag_reg <= 1'b1;
      end else if (wr_done && ofs == CCRB_OFS_PINREP && attr_in.wdata[CCRB_PIN_RRDY_BIT]) begin
        ready_change_flag_reg <= attr_in.wdata[CCRB_PIN_CRDY_BIT];
      end
      if (live_chg[0]) begin
        wp_change_flag_reg <= 1'b1;
      end else if (wr_done && ofs == CCRB_OFS_PINREP && attr_in.wdata[CCRB_PIN_WP_BIT]) begin
        wp_change_flag_reg <= attr_in.wdata[CCRB_PIN_CWP_BIT];
      end
    end
  end

  // ---------------------------------------------------------------
  // Socket and copy
  // ---------------------------------------------------------------
  // Only the drive number is kept; socket nibble and top three bits are dropped
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      drive_num_reg <= 1'b0;
    end else if (any_reset) begin
      drive_num_reg <= 1'b0;
    end else if (wr_done && ofs == CCRB_OFS_SOCKET) begin
      drive_num_reg <= attr_in.wdata[CCRB_SOC_DRV_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  assign changed_flag = ready_change_flag_reg | wp_change_flag_reg;
  assign int_status = irq_request & ~irq_disable_bit;

  // Byte-wide read mux; unmapped offsets answer zero
  always_comb begin
    rd_mux = CCRB_BYTE_ZERO;
    case (ofs)
      CCRB_OFS_OPTION: begin
        rd_mux = {soft_reset_bit_reg, level_irq_reg, config_index_reg};
      end
      CCRB_OFS_STATUS: begin
        rd_mux[CCRB_STS_CHANGED_BIT] = changed_flag;
        rd_mux[CCRB_STS_CHANGE_SIGNAL_ENABLE_BIT] = change_signal_enable_reg;
        rd_mux[CCRB_STS_IO8_BIT] = eight_bit_io_request_reg;
        rd_mux[CCRB_STS_PL1_BIT] = 1'b0; // Not writeable
        rd_mux[CCRB_STS_AUDIO_BIT] = audio_reg;
        rd_mux[CCRB_STS_PWRDN_BIT] = power_down_request_reg;
        rd_mux[CCRB_STS_INT_BIT] = int_status;
      end
      CCRB_OFS_PINREP: begin
        rd_mux = CCRB_PIN_FIXED_ONES;
        rd_mux[CCRB_PIN_CRDY_BIT] = ready_change_flag_reg;
        rd_mux[CCRB_PIN_CWP_BIT] = wp_change_flag_reg;
        rd_mux[CCRB_PIN_RRDY_BIT] = core_ready;
        rd_mux[CCRB_PIN_WP_BIT] = write_protect_state;
      end
      CCRB_OFS_SOCKET: begin
        rd_mux[CCRB_SOC_DRV_BIT] = drive_num_reg;
      end
      default: begin
        rd_mux = CCRB_BYTE_ZERO;
      end
    endcase
  end

  // Registered read data: one cycle behind the strobe, low byte only
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      attr_rdata <= CCRB_BYTE_ZERO;
      attr_rdata_oe <= 1'b0;
    end else begin
      attr_rdata <= rd_active ? rd_mux : CCRB_BYTE_ZERO;
      attr_rdata_oe <= rd_active;
    end
  end

  // ---------------------------------------------------------------
  // Decoded outputs
  // ---------------------------------------------------------------
  // Index decode; reserved upper bits fall back to memory mode
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      config_mode <= CCRB_MODE_MEM;
      io_configured <= 1'b0;
    end else begin
      case (config_index_reg)
        CCRB_INDEX_IO_ANY: begin
          config_mode <= CCRB_MODE_IO_ANY;
          io_configured <= 1'b1;
        end
        CCRB_INDEX_IO_PRI: begin
          config_mode <= CCRB_MODE_IO_PRI;
          io_configured <= 1'b1;
        end
        CCRB_INDEX_IO_SEC: begin
          config_mode <= CCRB_MODE_IO_SEC;
          io_configured <= 1'b1;
        end
        default: begin
          config_mode <= CCRB_MODE_MEM;
          io_configured <= 1'b0;
        end
      endcase
    end
  end

  // Pin outputs registered; status pin idles high outside I/O mode
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      status_change_pin <= 1'b1;
      ready_out <= 1'b0;
      card_reset <= 1'b1;
      level_irq_select <= 1'b0;
      power_down_target <= 1'b0;
      drive_select_bit <= 1'b0;
    end else begin
      status_change_pin <= !(changed_flag && change_signal_enable_reg && io_configured);
      ready_out <= core_ready && !busy_reg && !pwrdn_wr_change && !any_reset;
      card_reset <= any_reset;
      level_irq_select <= level_irq_reg;
      power_down_target <= power_down_request_reg | auto_sleep_reg;
      drive_select_bit <= drive_num_reg;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_soft_reset_bit_holds: assert property (soft_reset_bit_reg && !hw_reset
    && !(wr_done && ofs == CCRB_OFS_OPTION) |=> soft_reset_bit_reg)
    else $error("soft reset bit cleared by itself");
  a_hw_clears_soft_reset_bit: assert property (hw_reset |=> !soft_reset_bit_reg)
    else $error("hardware reset left soft reset set");
  a_reset_unconfig: assert property (any_reset
    |=> config_index_reg == CCRB_INDEX_RST && !level_irq_reg)
    else $error("reset did not clear configuration");
  a_status_change_pin_pin: assert property (##1 status_change_pin
    == !$past(changed_flag && change_signal_enable_reg && io_configured))
    else $error("status change pin wrong");
  a_status_change_pin_quiet: assert property (!change_signal_enable_reg && io_configured |=> status_change_pin)
    else $error("status pin low with change signal off");
  a_ready_busy: assert property (pwrdn_wr_change |=> !ready_out ##0 busy_reg)
    else $error("ready not busy after power request change");
  a_busy_holds: assert property (busy_reg
    && power_state_low != (power_down_request_reg | auto_sleep_reg) |=> busy_reg)
    else $error("busy dropped before power state reached");
  a_change_sets: assert property (live_chg[1] |=> ready_change_flag_reg)
    else $error("ready change not flagged");
  a_mask_keeps: assert property (wr_done && ofs == CCRB_OFS_PINREP
    && !attr_in.wdata[CCRB_PIN_RRDY_BIT] && !live_chg[1] |=> $stable(ready_change_flag_reg))
    else $error("masked flag changed");
  a_int_masked: assert property (irq_disable_bit |-> !int_status)
    else $error("interrupt status not masked");
  a_read_latency: assert property (rd_active && ofs == CCRB_OFS_PINREP |=> attr_rdata_oe
    && attr_rdata[CCRB_PIN_WP_BIT] == 1'b0 && attr_rdata[3:2] == 2'b11)
    else $error("pin read wrong");

  c_soft_reset: cover property (wr_done && ofs == CCRB_OFS_OPTION ##[1:50] !soft_reset_bit_reg);
  c_io_mode: cover property (io_configured && !status_change_pin);
  c_power_cycle: cover property (busy_reg ##[1:100] !busy_reg);
  c_flag_clear: cover property (ready_change_flag_reg ##1 !ready_change_flag_reg);

endmodule

`default_nettype wire

// ===== testbench/ccrb_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// Host socket controller side of the attribute bus
module ccrb_host_model (
  input wire logic mclk,
  output var ccrb_pkg::ccrb_attr_s attr,
  input wire logic [7:0] attr_rdata,
  input wire logic attr_rdata_oe
);
  import ccrb_pkg::*;

  // ---------------------------------------------------------------
  // Idle bus
  // ---------------------------------------------------------------
  initial begin
    attr = '{1'b1, 1'b1, 1'b1, 1'b1, 11'h7FF, 8'h00};
  end

  // ---------------------------------------------------------------
  // Access tasks
  // ---------------------------------------------------------------
  // Byte write on the low lane; address and data held two edges past the strobe
  // Released lines are inverted so a stale value can never decode as a match
  task automatic wr(input logic [10:0] a, input logic [7:0] d, input logic rb = 1'b0);
    @(posedge mclk);
    attr <= '{1'b0, rb, 1'b1, 1'b0, a, d};
    @(posedge mclk);
    attr.we_b <= 1'b1;
    repeat (2) @(posedge mclk);
    attr <= '{1'b1, 1'b1, 1'b1, 1'b1, ~a, ~d};
    // One more edge so outputs registered from the new fields have launched
    @(posedge mclk);
  endtask

  // Byte read; registered data is taken at the edge after the one that launched it
  task automatic rd(input logic [10:0] a, output logic [7:0] d, output logic oe);
    @(posedge mclk);
    attr <= '{1'b0, 1'b0, 1'b0, 1'b1, a, 8'h00};
    repeat (2) @(posedge mclk);
    d = attr_rdata;
    oe = attr_rdata_oe;
    attr <= '{1'b1, 1'b1, 1'b1, 1'b1, ~a, 8'hFF};
  endtask
endmodule

`default_nettype wire

// ===== testbench/ccrb_card_config_register_bank_tb.sv
`timescale 1ns/1ps
`default_nettype none

module ccrb_card_config_register_bank_tb;
  import ccrb_pkg::*;

  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  localparam logic [10:0] OPT = CCRB_BASE_ADDR | 11'(CCRB_OFS_OPTION);
  localparam logic [10:0] STS = CCRB_BASE_ADDR | 11'(CCRB_OFS_STATUS);
  localparam logic [10:0] PIN = CCRB_BASE_ADDR | 11'(CCRB_OFS_PINREP);
  localparam logic [10:0] SOC = CCRB_BASE_ADDR | 11'(CCRB_OFS_SOCKET);
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic hw_reset = 1'b0, irq_request = 1'b0, irq_disable_bit = 1'b0, core_ready = 1'b0;
  logic core_idle = 1'b0, command_received = 1'b0, power_state_low = 1'b0;
  ccrb_attr_s attr_in;
  logic [7:0] attr_rdata, rdat;
  logic attr_rdata_oe, status_change_pin, ready_out, card_reset, level_irq_select, roe;
  logic io_configured, power_down_target, drive_select_bit;
  ccrb_mode_e config_mode;
  ccrb_mode_e modes [4] = '{CCRB_MODE_MEM, CCRB_MODE_IO_ANY, CCRB_MODE_IO_PRI, CCRB_MODE_IO_SEC};
  int n_errors = 0;
  int n_checks = 0;
  int cycles = 0;

  always #5 mclk = ~mclk;

  ccrb_card_config_register_bank dut (
    .mclk(mclk), .rst_b(rst_b), .hw_reset(hw_reset), .attr_in(attr_in),
    .irq_request(irq_request), .irq_disable_bit(irq_disable_bit), .core_ready(core_ready),
    .core_idle(core_idle), .command_received(command_received), .power_state_low(power_state_low),
    .attr_rdata(attr_rdata), .attr_rdata_oe(attr_rdata_oe), .status_change_pin(status_change_pin),
    .ready_out(ready_out), .card_reset(card_reset), .level_irq_select(level_irq_select),
    .config_mode(config_mode), .io_configured(io_configured), .power_down_target(power_down_target),
    .drive_select_bit(drive_select_bit)
  );

  ccrb_host_model host (
    .mclk(mclk), .attr(attr_in), .attr_rdata(attr_rdata), .attr_rdata_oe(attr_rdata_oe)
  );

  // ---------------------------------------------------------------
  // Checking and closing
  // ---------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Read must be answered with the enable up as well as the right byte
  task automatic rchk(input logic [10:0] a, input logic [7:0] exp);
    host.rd(a, rdat, roe);
    chk(8'(roe), 8'h01, "read enable");
    chk(rdat, exp, "read data");
  endtask

  task automatic stop_test();
    $display("Checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Ceiling well above the few hundred cycles the sequence needs
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      $display("BAD t=%0t timeout", $time);
      stop_test();
    end
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    rchk(OPT, 8'h00);
    rchk(STS, 8'h00);
    rchk(PIN, CCRB_PIN_FIXED_ONES);
    rchk(SOC, 8'h00);
    chk(8'(card_reset), 8'h00, "card reset");
    $display("reset values done");
    // Every documented index value, upper bits kept zero
    for (int i = 0; i < 4; i++) begin
      host.wr(OPT, 8'(i));
      chk(8'(config_mode), 8'(modes[i]), "mode");
      chk(8'(io_configured), 8'(i != 0), "io configured");
    end
    host.wr(OPT, 8'h43);
    rchk(OPT, 8'h43);
    chk(8'(level_irq_select), 8'h01, "level irq");
    $display("config index done");
    // Live ready change sets its flag; flags, masks and the status pin
    @(posedge mclk);
    core_ready <= 1'b1;
    repeat (3) @(posedge mclk);
    rchk(PIN, 8'h2E);
    rchk(STS, 8'h80);
    chk(8'(status_change_pin), 8'h01, "status_change_pin disabled");
    host.wr(STS, 8'h40);
    repeat (2) @(posedge mclk);
    chk(8'(status_change_pin), 8'h00, "status_change_pin on");
    host.wr(PIN, 8'h20);
    rchk(PIN, 8'h2E);
    host.wr(PIN, 8'h12);
    rchk(PIN, 8'h0E);
    chk(8'(status_change_pin), 8'h01, "status_change_pin cleared");
    host.wr(PIN, 8'h11);
    rchk(PIN, 8'h1E);
    chk(8'(status_change_pin), 8'h00, "status_change_pin wp");
    host.wr(STS, 8'h00);
    repeat (2) @(posedge mclk);
    chk(8'(status_change_pin), 8'h01, "status_change_pin off");
    host.wr(PIN, 8'h03);
    rchk(PIN, 8'h0E);
    $display("change flags done");
    // Power-down request holds ready busy until the core reports the state
    host.wr(STS, 8'h34);
    chk(8'(ready_out), 8'h00, "busy down");
    rchk(STS, 8'h24);
    @(posedge mclk);
    power_state_low <= 1'b1;
    repeat (3) @(posedge mclk);
    chk(8'(ready_out), 8'h01, "ready down");
    host.wr(STS, 8'h20);
    chk(8'(ready_out), 8'h00, "busy up");
    power_state_low <= 1'b0;
    repeat (3) @(posedge mclk);
    chk(8'(ready_out), 8'h01, "ready up");
    $display("power down done");
    // Interrupt status follows the request, hidden while disabled
    irq_request <= 1'b1;
    rchk(STS, 8'h22);
    irq_disable_bit <= 1'b1;
    rchk(STS, 8'h20);
    irq_request <= 1'b0;
    irq_disable_bit <= 1'b0;
    // Socket number ignored, drive number kept
    host.wr(SOC, 8'h1F);
    rchk(SOC, 8'h10);
    chk(8'(drive_select_bit), 8'h01, "drive");
    host.wr(SOC, 8'h05);
    rchk(SOC, 8'h00);
    $display("status and socket done");
    // Accesses outside the register space change nothing
    host.wr(OPT | 11'h001, 8'h01);
    host.wr(11'h400, 8'h01);
    host.wr(OPT, 8'h01, 1'b1);
    rchk(OPT, 8'h43);
    host.rd(OPT | 11'h001, rdat, roe);
    chk(8'(roe), 8'h00, "odd read");
    $display("refused access done");
    // Soft reset held, released, then hardware reset
    host.wr(OPT, 8'h80);
    repeat (10) @(posedge mclk);
    chk(8'(card_reset), 8'h01, "soft reset");
    rchk(OPT, 8'h80);
    host.wr(OPT, 8'h00);
    repeat (2) @(posedge mclk);
    chk(8'(card_reset), 8'h00, "reset released");
    chk(8'(io_configured), 8'h00, "unconfigured");
    rchk(STS, 8'h00);
    host.wr(OPT, 8'h41);
    rchk(OPT, 8'h41);
    host.wr(OPT, 8'hC1);
    @(posedge mclk);
    hw_reset <= 1'b1;
    @(posedge mclk);
    hw_reset <= 1'b0;
    repeat (2) @(posedge mclk);
    rchk(OPT, 8'h00);
    $display("reset done");
    // Idle core sleeps on its own and wakes on a command
    core_idle <= 1'b1;
    repeat (3) @(posedge mclk);
    chk(8'(power_down_target), 8'h01, "idle sleep");
    core_idle <= 1'b0;
    command_received <= 1'b1;
    @(posedge mclk);
    command_received <= 1'b0;
    repeat (3) @(posedge mclk);
    chk(8'(power_down_target), 8'h00, "wake");
    $display("idle done");
    stop_test();
  end
endmodule

`default_nettype wire
